// File: design/char_oled_command_decoder.sv
// Command and data decoder for the character display controller
//
// Function
// - Byte 001xxxxx is function set; bit3 lines, bit2 height, bit1 extended, bit0 special.
// - Line count bit picks 1 or 2 lines, or 3 or 4 in four-line mode.
// - Double height gives 5x16 on two lines; one-line double height is forbidden.
// - Function set with extended bit takes bit2 as blink and bit0 as reverse.
// - Scan, shift, scroll, height format and blink/reverse bits load only in extended mode.
// - Reverse display inverts every displayed dot.
// - Blink enable makes user characters blink, using the top two row bits.
// - Byte 01xxxxxx outside extended mode loads a 6-bit user RAM address and selects user RAM.
// - Byte 1xxxxxxx outside extended mode loads a 7-bit display RAM address.
// - Two-line mode: 00-27 first line, 40-67 second line.
// - Three-line mode: 00-13, 20-33, 40-53.
// - Four-line mode adds a fourth line at 60-73.
// - Byte 1xxxxxxx in extended mode sets scroll quantity, saturating at 48 dots.
// - Each line enable covers eight common rows, 0-7 through 24-31.
// - Status read returns busy on bit 7 and address or identity below.
// - First status read returns the address, an immediate second returns the identity.
// - Data write stores the byte in the RAM chosen by the last address command.
// - Every RAM data write or read steps the address counter by one.
// - First data read after an address set is invalid; host does a dummy read.
// - Cursor shift reloads the read data register like an address set.
// - After a write steps the counter, a read returns the earlier latched data.
// - Increment direction high counts up, low counts down.
`include "char_oled_map.svh"
module char_oled_command_decoder #(
   parameter int         BUSY_CYCLES = `BUSY_CYCLES_DEF,
   parameter logic [6:0] PART_ID     = `PART_ID_DEF  // Arbitrary identification value
) (
   // Clock and reset
   input  wire logic                      ref_clk,
   input  wire logic                      rst_b,
   // Host access
   input  wire char_oled_pkg::host_req_t  hostReq,
   input  wire logic                      incrementDirection,
   output char_oled_pkg::host_rsp_t       hostRsp,
   output logic                           busyFlag,
   // Configuration
   output char_oled_pkg::disp_cfg_t       dispCfg,
   output logic      [5:0]                scrollDots,
   // Address status
   output logic      [1:0]                lineIndex,
   output logic                           addrInRange,
   // Row and dot path
   input  wire logic [4:0]                comRow,
   input  wire char_oled_pkg::dot_in_t    dotIn,
   output logic                           rowShiftEn,
   output logic                           rowScrollEn,
   output logic                           dotOut
);
   import char_oled_pkg::*;

   localparam dec_state_t RESET_STATE = '{phase: ST_READY, ramSel: RAM_DISPLAY, default: '0};

   dec_state_t s_reg;
   dec_state_t s_next;
   logic [7:0] dispQ;
   logic [7:0] userQ;
   logic [7:0] ramQ;
   logic       dispWe;
   logic       userWe;
   logic [1:0] mapLine;
   logic       mapInRange;
   logic       mapShift;
   logic       mapScroll;
   logic       busyRd;
   logic       accReady;
   logic       cmdGo;
   logic       wrGo;
   logic       rdGo;
   logic [7:0] cmd;

   function automatic logic [6:0] stepAddr(input logic [6:0] a, input ram_sel_t sel, input logic up);
      logic [6:0] n;
      n = up ? 7'(a + 7'h01) : 7'(a - 7'h01);
      if (sel == RAM_USER) begin
         n[6] = 1'b0;
      end
      return n;
   endfunction

   assign cmd      = hostReq.data;
   assign busyRd   = hostReq.valid && !hostReq.cmdDataSel && hostReq.readWriteSel;
   assign accReady = hostReq.valid && (s_reg.phase == ST_READY) && !busyRd;
   assign cmdGo    = accReady && !hostReq.cmdDataSel && !hostReq.readWriteSel;
   assign wrGo     = accReady && hostReq.cmdDataSel && !hostReq.readWriteSel;
   assign rdGo     = accReady && hostReq.cmdDataSel && hostReq.readWriteSel;
   assign ramQ     = (s_reg.ramSel == RAM_USER) ? userQ : dispQ;
   assign dispWe   = wrGo && (s_reg.ramSel == RAM_DISPLAY);
   assign userWe   = wrGo && (s_reg.ramSel == RAM_USER);

   char_ram #(.AW(7), .DEPTH(128)) u_disp_ram (
      .ref_clk (ref_clk),
      .we      (dispWe),
      .addr    (s_reg.addr),
      .wdata   (cmd),
      .rdata   (dispQ)
   );

   char_ram #(.AW(6), .DEPTH(64)) u_user_ram (
      .ref_clk (ref_clk),
      .we      (userWe),
      .addr    (s_reg.addr[5:0]),
      .wdata   (cmd),
      .rdata   (userQ)
   );

   display_line_map u_line_map (
      .addr         (s_reg.addr),
      .fourLineMode (s_reg.cfg.fourLineMode),
      .lineCountSel (s_reg.cfg.lineCountSel),
      .comRow       (comRow),
      .lineShiftEn  (s_reg.cfg.lineShiftEn),
      .lineScrollEn (s_reg.cfg.lineScrollEn),
      .lineIndex    (mapLine),
      .inRange      (mapInRange),
      .rowShift     (mapShift),
      .rowScroll    (mapScroll)
   );

   always_comb begin
      s_next           = s_reg;
      s_next.rsp.valid = 1'b0;
      s_next.lineIdx   = mapLine;
      s_next.inRange   = mapInRange;
      s_next.rowShift  = mapShift;
      s_next.rowScroll = mapScroll;
      // Reverse inverts after user-font blink has blanked the dot
      s_next.dot = s_reg.cfg.reverseDisplay ^
                   (dotIn.pix & ~(s_reg.cfg.cgramBlinkEn & dotIn.userChar &
                                  dotIn.blinkPhase & (|dotIn.blinkRows)));
      s_next.scrollDots = (s_reg.cfg.scrollQuantity[5:4] == `SCROLL_SAT) ?
                          `SCROLL_MAX : s_reg.cfg.scrollQuantity;

      if (s_reg.phase == ST_BUSY) begin
         s_next.busyCnt = 8'(s_reg.busyCnt - 8'h01);
         if (s_reg.busyCnt == 8'h01) begin
            s_next.phase = ST_READY;
         end
      end

      if (busyRd) begin
         s_next.rsp.valid = 1'b1;
         s_next.rsp.data  = {(s_reg.phase == ST_BUSY),
                             s_reg.idNext ? PART_ID : s_reg.addr};
         s_next.idNext    = !s_reg.idNext;
      end else if (hostReq.valid) begin
         s_next.idNext = 1'b0;
      end

      if (accReady) begin
         s_next.phase   = ST_BUSY;
         s_next.busyCnt = 8'(BUSY_CYCLES);
      end

      if (wrGo) begin
         s_next.addr = stepAddr(s_reg.addr, s_reg.ramSel, incrementDirection);
      end

      if (rdGo) begin
         // The read register lags the counter by one access
         s_next.rsp.valid = 1'b1;
         s_next.rsp.data  = s_reg.outData;
         s_next.outData   = ramQ;
         s_next.addr      = stepAddr(s_reg.addr, s_reg.ramSel, incrementDirection);
      end

      if (cmdGo) begin
         if (s_reg.cfg.extRegSelect && cmd[7:1] == `OP_OLED_SEL) begin
            s_next.cfg.oledCmdSetSel = cmd[0];
         end else if (s_reg.cfg.oledCmdSetSel) begin
            // Command-set mode: basic table disabled
            s_next.cfg = s_reg.cfg;
         end else if (cmd[7]) begin
            if (s_reg.cfg.extRegSelect) begin
               s_next.cfg.scrollQuantity = cmd[5:0];
            end else begin
               s_next.addr    = cmd[6:0];
               s_next.ramSel  = RAM_DISPLAY;
               // Stale RAM output is latched, so the next read is the dummy
               s_next.outData = ramQ;
            end
         end else if (cmd[7:6] == `OP_USER_CHAR_RAM_ADDR && !s_reg.cfg.extRegSelect) begin
            s_next.addr    = {1'b0, cmd[5:0]};
            s_next.ramSel  = RAM_USER;
            s_next.outData = ramQ;
         end else if (cmd[7:5] == `OP_FUNC_SET) begin
            s_next.cfg.lineCountSel = cmd[`FS_LINES_BIT];
            s_next.cfg.extRegSelect = cmd[`FS_RE_BIT];
            if (cmd[`FS_RE_BIT]) begin
               s_next.cfg.cgramBlinkEn   = cmd[`FS_DH_BE_BIT];
               s_next.cfg.reverseDisplay = cmd[`FS_IS_REV_BIT];
            end else begin
               s_next.cfg.doubleHeightEn   = cmd[`FS_DH_BE_BIT];
               s_next.cfg.specialRegSelect = cmd[`FS_IS_REV_BIT];
            end
         end else if (cmd[7:4] == `OP_SHIFT) begin
            if (s_reg.cfg.extRegSelect) begin
               if (!s_reg.cfg.specialRegSelect) begin
                  s_next.cfg.heightFormatHi = cmd[3];
                  s_next.cfg.heightFormatLo = cmd[2];
                  s_next.cfg.shiftModeSel   = cmd[0];
               end else if (s_reg.cfg.shiftModeSel) begin
                  s_next.cfg.lineShiftEn = cmd[3:0];
               end else begin
                  s_next.cfg.lineScrollEn = cmd[3:0];
               end
            end else if (!s_reg.cfg.specialRegSelect && !cmd[3]) begin
               // Cursor shift: bit2 picks the direction
               s_next.addr    = stepAddr(s_reg.addr, s_reg.ramSel, cmd[2]);
               s_next.outData = ramQ;
            end
         end else if (cmd[7:3] == `OP_EXT_FUNC) begin
            if (s_reg.cfg.extRegSelect) begin
               s_next.cfg.fourLineMode = cmd[0];
            end
         end else if (cmd[7:2] == `OP_ENTRY) begin
            if (s_reg.cfg.extRegSelect) begin
               s_next.cfg.comScanDir = cmd[1];
               s_next.cfg.segScanDir = cmd[0];
            end
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_reg <= RESET_STATE;
      end else begin
         s_reg <= s_next;
      end
   end

   assign hostRsp     = s_reg.rsp;
   assign busyFlag    = (s_reg.phase == ST_BUSY);
   assign dispCfg     = s_reg.cfg;
   assign scrollDots  = s_reg.scrollDots;
   assign lineIndex   = s_reg.lineIdx;
   assign addrInRange = s_reg.inRange;
   assign rowShiftEn  = s_reg.rowShift;
   assign rowScrollEn = s_reg.rowScroll;
   assign dotOut      = s_reg.dot;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   sequence firstStatusRd;
      busyRd && !s_reg.idNext;
   endsequence

   sequence secondStatusRd;
      busyRd && s_reg.idNext;
   endsequence

   status_addr_a: assert property (firstStatusRd |=>
      hostRsp.valid && hostRsp.data[6:0] == $past(s_reg.addr))
      else $error("status read did not return the address");

   status_id_a: assert property (secondStatusRd |=>
      hostRsp.valid && hostRsp.data[6:0] == PART_ID)
      else $error("second status read did not return the identity");

   status_busy_a: assert property (busyRd |=> hostRsp.data[7] == $past(busyFlag))
      else $error("busy bit does not match internal state");

   user_addr_a: assert property (cmdGo && !s_reg.cfg.oledCmdSetSel && !s_reg.cfg.extRegSelect &&
      cmd[7:6] == 2'b01 |=> s_reg.ramSel == RAM_USER && s_reg.addr == {1'b0, $past(cmd[5:0])})
      else $error("user RAM address not loaded");

   disp_addr_a: assert property (cmdGo && !s_reg.cfg.oledCmdSetSel && !s_reg.cfg.extRegSelect &&
      cmd[7] |=> s_reg.ramSel == RAM_DISPLAY && s_reg.addr == $past(cmd[6:0]))
      else $error("display RAM address not loaded");

   scroll_sat_a: assert property (cmdGo && !s_reg.cfg.oledCmdSetSel && s_reg.cfg.extRegSelect &&
      cmd[7] && cmd[5:4] == 2'b11 |=> ##1 scrollDots == 6'h30)
      else $error("saturated scroll quantity is not 48 dots");

   write_step_a: assert property (wrGo && incrementDirection && s_reg.ramSel == RAM_DISPLAY |=>
      s_reg.addr == 7'($past(s_reg.addr) + 7'h01))
      else $error("address did not step up after write");

   read_latched_a: assert property (rdGo |=> hostRsp.valid &&
      hostRsp.data == $past(s_reg.outData))
      else $error("read did not return the latched data");

   busy_hold_a: assert property (accReady |=> busyFlag ##1 busyFlag)
      else $error("busy not held after an accepted access");

   reverse_dot_a: assert property (s_reg.cfg.reverseDisplay && !s_reg.cfg.cgramBlinkEn |=>
      dotOut == !$past(dotIn.pix))
      else $error("reverse display did not invert the dot");

endmodule

// File: design/char_oled_map.svh
// Command codes, field positions, address ranges and counts for the character display decoder
`ifndef CHAR_OLED_MAP_SVH
`define CHAR_OLED_MAP_SVH

// Command opcodes, compared against the top bits of a command byte
`define OP_FUNC_SET      3'b001
`define OP_USER_CHAR_RAM_ADDR    2'b01
`define OP_SHIFT         4'b0001
`define OP_EXT_FUNC      5'b00001
`define OP_ENTRY         6'b000001
`define OP_OLED_SEL      7'b0111100

// Function set field positions
`define FS_LINES_BIT     3
`define FS_DH_BE_BIT     2
`define FS_RE_BIT        1
`define FS_IS_REV_BIT    0

// Scroll quantity saturation
`define SCROLL_SAT       2'b11
`define SCROLL_MAX       6'h30

// Display RAM line ranges
`define L1_LAST          7'h4f
`define L2A_LAST         7'h27
`define L2B_FIRST        7'h40
`define L2B_LAST         7'h67
`define LINE_COL_LAST    5'h13

// Reset values and counts
`define ADDR_RESET       7'h00
`define BUSY_CYCLES_DEF  4
`define PART_ID_DEF      7'h2a

`endif

// File: design/char_oled_pkg.sv
// Types shared by the character display decoder
package char_oled_pkg;

   typedef enum logic [1:0] {
      ST_READY = 2'b01,
      ST_BUSY  = 2'b10
   } phase_t;

   typedef enum logic {
      RAM_DISPLAY = 1'b0,
      RAM_USER    = 1'b1
   } ram_sel_t;

   typedef struct packed {
      logic       valid;
      logic       cmdDataSel;
      logic       readWriteSel;
      logic [7:0] data;
   } host_req_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } host_rsp_t;

   typedef struct packed {
      logic       pix;
      logic       userChar;
      logic       blinkPhase;
      logic [1:0] blinkRows;
   } dot_in_t;

   typedef struct packed {
      logic       extRegSelect;
      logic       specialRegSelect;
      logic       oledCmdSetSel;
      logic       fourLineMode;
      logic       lineCountSel;
      logic       doubleHeightEn;
      logic       cgramBlinkEn;
      logic       reverseDisplay;
      logic       segScanDir;
      logic       comScanDir;
      logic       heightFormatHi;
      logic       heightFormatLo;
      logic       shiftModeSel;
      logic [3:0] lineShiftEn;
      logic [3:0] lineScrollEn;
      logic [5:0] scrollQuantity;
   } disp_cfg_t;

   typedef struct packed {
      phase_t     phase;
      logic [7:0] busyCnt;
      disp_cfg_t  cfg;
      logic [6:0] addr;
      ram_sel_t   ramSel;
      logic       idNext;
      logic [7:0] outData;
      host_rsp_t  rsp;
      logic [5:0] scrollDots;
      logic [1:0] lineIdx;
      logic       inRange;
      logic       rowShift;
      logic       rowScroll;
      logic       dot;
   } dec_state_t;

endpackage

// File: design/char_ram.sv
// Synchronous character RAM with registered read port
module char_ram #(
   parameter int AW    = 7,
   parameter int DEPTH = 128
) (
   // Clock
   input  wire logic          ref_clk,
   // Access
   input  wire logic          we,
   input  wire logic [AW-1:0] addr,
   input  wire logic [7:0]    wdata,
   output logic      [7:0]    rdata
);

   logic [7:0] mem [DEPTH];

   // Read data lags the address by one edge
   always_ff @(posedge ref_clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end

endmodule

// File: design/display_line_map.sv
// Maps a display RAM address to its line, and a common row to its line enables
`include "char_oled_map.svh"
module display_line_map (
   // Address and mode
   input  wire logic [6:0] addr,
   input  wire logic       fourLineMode,
   input  wire logic       lineCountSel,
   // Row gating
   input  wire logic [4:0] comRow,
   input  wire logic [3:0] lineShiftEn,
   input  wire logic [3:0] lineScrollEn,
   // Results
   output logic      [1:0] lineIndex,
   output logic            inRange,
   output logic            rowShift,
   output logic            rowScroll
);

   logic [3:0] rowHit;

   // Each enable bit owns eight common rows
   for (genvar g = 0; g < 4; g++) begin : g_row
      assign rowHit[g] = (comRow[4:3] == 2'(g));
   end
   assign rowShift  = |(rowHit & lineShiftEn);
   assign rowScroll = |(rowHit & lineScrollEn);

   always_comb begin
      lineIndex = 2'h0;
      inRange   = 1'b0;
      if (!fourLineMode) begin
         if (!lineCountSel) begin
            inRange = (addr <= `L1_LAST);
         end else if (addr <= `L2A_LAST) begin
            inRange = 1'b1;
         end else if (addr >= `L2B_FIRST && addr <= `L2B_LAST) begin
            lineIndex = 2'h1;
            inRange   = 1'b1;
         end
      end else begin
         // Lines start at 00, 20, 40 and 60 hex; the fourth exists only when the line count bit is set
         lineIndex = addr[6:5];
         inRange   = (addr[4:0] <= `LINE_COL_LAST) && (lineCountSel || addr[6:5] != 2'h3);
      end
   end

endmodule

// File: verification/char_oled_command_decoder_tb.sv
// Testbench for the character display command decoder
`define CHECK(a, b) begin cmpCount++; if ((a) !== (b)) begin nErrors++; $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module char_oled_command_decoder_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import char_oled_pkg::*;

   localparam logic [6:0] PartId = 7'h15; // Arbitrary identification value

   logic       ref_clk;
   logic       rst_b;
   host_req_t  hostReq;
   host_rsp_t  hostRsp;
   host_rsp_t  r;
   logic       busyFlag;
   logic       incrementDirection;
   disp_cfg_t  dispCfg;
   logic [5:0] scrollDots;
   logic [1:0] lineIndex;
   logic       addrInRange;
   logic [4:0] comRow;
   dot_in_t    dotIn;
   logic       rowShiftEn;
   logic       rowScrollEn;
   logic       dotOut;
   logic [2:0] expL;
   int         nErrors;
   int         cmpCount;
   logic [6:0] addrs [12] = '{7'h00, 7'h13, 7'h14, 7'h27, 7'h28, 7'h33, 7'h40, 7'h4f, 7'h50, 7'h60, 7'h73, 7'h74};
   logic [5:0] sq [5] = '{6'h00, 6'h01, 6'h2f, 6'h30, 6'h3f};

   char_oled_command_decoder #(.BUSY_CYCLES(4), .PART_ID(PartId)) char_oled_command_decoder_inst (
      .ref_clk(ref_clk), .rst_b(rst_b), .hostReq(hostReq), .incrementDirection(incrementDirection),
      .hostRsp(hostRsp), .busyFlag(busyFlag), .dispCfg(dispCfg), .scrollDots(scrollDots),
      .lineIndex(lineIndex), .addrInRange(addrInRange), .comRow(comRow), .dotIn(dotIn),
      .rowShiftEn(rowShiftEn), .rowScrollEn(rowScrollEn), .dotOut(dotOut));

   char_oled_host_model char_oled_host_model_inst (
      .ref_clk(ref_clk), .hostReq(hostReq), .hostRsp(hostRsp), .busyFlag(busyFlag));

   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   task automatic stop_test();
      $display("errors %0d, comparisons %0d", nErrors, cmpCount);
      if (nErrors == 0 && cmpCount > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic waitIdle();
      int n;
      n = 0;
      @(negedge ref_clk);
      while (busyFlag !== 1'b0 && n < 50) begin
         @(negedge ref_clk);
         n++;
      end
      @(negedge ref_clk);
   endtask

   task automatic cmd(input logic [7:0] c);
      char_oled_host_model_inst.access(1'b0, 1'b0, c, r);
      waitIdle();
   endtask

   task automatic dat(input logic [7:0] d);
      char_oled_host_model_inst.access(1'b1, 1'b0, d, r);
      waitIdle();
   endtask

   task automatic stat(input logic [7:0] e);
      char_oled_host_model_inst.access(1'b0, 1'b1, 8'h00, r);
      `CHECK(r.valid, 1'b1)
      `CHECK(r.data, e)
   endtask

   task automatic rdat(input logic [7:0] e);
      char_oled_host_model_inst.access(1'b1, 1'b1, 8'h00, r);
      `CHECK(r.valid, 1'b1)
      `CHECK(r.data, e)
      waitIdle();
   endtask

   task automatic dotSweep(input logic reverse_display, input logic bl);
      for (int i = 0; i < 32; i++) begin
         dotIn = dot_in_t'(i[4:0]);
         @(negedge ref_clk);
         `CHECK(dotOut, reverse_display ^ (dotIn.pix & ~(bl & dotIn.userChar & dotIn.blinkPhase & |dotIn.blinkRows)))
      end
   endtask

   // Switches line mode through the extended table and returns to the basic one
   task automatic setMode(input logic f, input logic l);
      cmd({4'h2, l, 3'h2});
      cmd({7'h04, f});
      cmd({4'h2, l, 3'h0});
      `CHECK(dispCfg.fourLineMode, f)
      `CHECK(dispCfg.lineCountSel, l)
   endtask

   function automatic logic [2:0] expLine(logic f, logic l, logic [6:0] a);
      if (!f && !l) return {a <= 7'h4f, 2'h0};
      if (!f) return {(a <= 7'h27) || (a >= 7'h40 && a <= 7'h67), 1'b0, a[6]};
      return {a[4:0] <= 5'h13 && (l || a[6:5] != 2'b11), a[6:5]};
   endfunction

   initial begin
      repeat (40000) @(posedge ref_clk);
      nErrors++;
      stop_test();
   end

   initial begin
      nErrors = 0;
      cmpCount = 0;
      rst_b = 1'b0;
      incrementDirection = 1'b1;
      comRow = 5'h00;
      dotIn = '0;
      repeat (10) @(posedge ref_clk);
      @(negedge ref_clk);
      rst_b = 1'b1;
      `CHECK(dispCfg, '0)
      // Status read straight after a command sees busy
      char_oled_host_model_inst.access(1'b0, 1'b0, 8'h2c, r);
      stat(8'h80);
      waitIdle();
      `CHECK({dispCfg.lineCountSel, dispCfg.doubleHeightEn, dispCfg.extRegSelect}, 3'h6)
      cmd(8'h2f);
      `CHECK({dispCfg.extRegSelect, dispCfg.cgramBlinkEn, dispCfg.reverseDisplay, dispCfg.doubleHeightEn}, 4'hf)
      dotSweep(1'b1, 1'b1);
      cmd(8'h2b);
      dotSweep(1'b1, 1'b0);
      cmd(8'h09);
      cmd(8'h06);
      cmd(8'h1d);
      `CHECK({dispCfg.fourLineMode, dispCfg.comScanDir, dispCfg.segScanDir}, 3'h6)
      `CHECK({dispCfg.heightFormatHi, dispCfg.heightFormatLo, dispCfg.shiftModeSel}, 3'h7)
      for (int i = 0; i < 5; i++) begin
         cmd({2'b10, sq[i]});
         `CHECK(dispCfg.scrollQuantity, sq[i])
         `CHECK(scrollDots, (sq[i][5:4] == 2'b11) ? 6'h30 : sq[i])
      end
      cmd(8'h29);
      cmd(8'h2e);
      cmd(8'h15);
      `CHECK({dispCfg.specialRegSelect, dispCfg.lineShiftEn}, 5'h15)
      for (int c = 0; c < 32; c++) begin
         comRow = 5'(c);
         @(negedge ref_clk);
         `CHECK(rowShiftEn, 1'(4'h5 >> c[4:3]))
         `CHECK(rowScrollEn, 1'b0)
      end
      dotSweep(1'b0, 1'b1);
      cmd(8'h28);
      cmd(8'h04);
      `CHECK({dispCfg.comScanDir, dispCfg.specialRegSelect}, 2'h2)
      for (int m = 0; m < 4; m++) begin
         setMode(m < 2, m[0] == 1'b0);
         for (int i = 0; i < 12; i++) begin
            cmd({1'b1, addrs[i]});
            expL = expLine(m < 2, m[0] == 1'b0, addrs[i]);
            `CHECK(addrInRange, expL[2])
            if (expL[2]) `CHECK(lineIndex, expL[1:0])
            stat({1'b0, addrs[i]});
         end
      end
      stat({1'b0, PartId});
      stat(8'h74);
      stat({1'b0, PartId});
      cmd(8'h90);
      for (int i = 1; i < 5; i++) dat(8'ha0 + 8'(i));
      stat(8'h14);
      cmd(8'h90);
      char_oled_host_model_inst.dummyRead();
      waitIdle();
      rdat(8'ha1);
      rdat(8'ha2);
      stat(8'h13);
      incrementDirection = 1'b0;
      rdat(8'ha3);
      stat(8'h12);
      dat(8'h55);
      rdat(8'ha4);
      incrementDirection = 1'b1;
      cmd(8'h50);
      dat(8'h3c);
      cmd(8'h90);
      char_oled_host_model_inst.dummyRead();
      waitIdle();
      rdat(8'ha1);
      cmd(8'h50);
      char_oled_host_model_inst.dummyRead();
      waitIdle();
      rdat(8'h3c);
      cmd(8'h90);
      cmd(8'h14);
      stat(8'h11);
      char_oled_host_model_inst.dummyRead();
      waitIdle();
      rdat(8'ha2);
      cmd(8'h2a);
      rst_b = 1'b0;
      repeat (3) @(negedge ref_clk);
      `CHECK(dispCfg, '0)
      `CHECK(busyFlag, 1'b0)
      rst_b = 1'b1;
      stat(8'h00);
      stop_test();
   end
endmodule

// File: verification/char_oled_host_model.sv
// Host model that issues commands, RAM data and status reads to the decoder
module char_oled_host_model (
   // Clock
   input  wire logic                     ref_clk,
   // Decoder access
   output char_oled_pkg::host_req_t      hostReq,
   input  wire char_oled_pkg::host_rsp_t hostRsp,
   input  wire logic                     busyFlag
);
   timeunit 1ns;
   timeprecision 100ps;
   import char_oled_pkg::*;

   initial hostReq = '0;

   // One access; anything but a status read first waits for the decoder to go idle
   task automatic access(input logic cds, input logic rw, input logic [7:0] d, output host_rsp_t r);
      int n;
      n = 0;
      @(negedge ref_clk);
      while (!(cds == 1'b0 && rw == 1'b1) && busyFlag !== 1'b0 && n < 200) begin
         @(negedge ref_clk);
         n++;
      end
      hostReq = '{valid: 1'b1, cmdDataSel: cds, readWriteSel: rw, data: d};
      @(negedge ref_clk);
      // The answer strobe stands only in the cycle after the taking edge
      r = rw ? hostRsp : '0;
      // Released lines show the inverse so stale values never pass for good ones
      hostReq = '{valid: 1'b0, cmdDataSel: ~cds, readWriteSel: ~rw, data: ~d};
   endtask

   // Throws away the stale first read after an address set
   task automatic dummyRead();
      host_rsp_t r;
      access(1'b1, 1'b1, 8'h00, r);
   endtask
endmodule
